// file: inc/useq_pkg.sv
`default_nettype none
package useq_pkg;
    // stack control codes
    localparam logic [2:0] STK_RESET = 3'h0;
    localparam logic [2:0] STK_CLEAR = 3'h1;
    localparam logic [2:0] STK_POP_ELSE = 3'h2;
    localparam logic [2:0] STK_POP_IF = 3'h3;
    localparam logic [2:0] STK_PUSH_ELSE = 3'h4;
    localparam logic [2:0] STK_PUSH_IF = 3'h5;
    localparam logic [2:0] STK_PUSH_BUT = 3'h6;
    localparam logic [2:0] STK_READ = 3'h7;
    // register/counter control codes
    localparam logic [2:0] CNT_DEC_A = 3'h1;
    localparam logic [2:0] CNT_LD_A = 3'h2;
    localparam logic [2:0] CNT_DEC_A_LD_B = 3'h3;
    localparam logic [2:0] CNT_LD_AB = 3'h4;
    localparam logic [2:0] CNT_DEC_B = 3'h5;
    localparam logic [2:0] CNT_LD_B = 3'h6;
    localparam logic [2:0] CNT_LD_A_DEC_B = 3'h7;
    // next-address sources
    localparam logic [1:0] SRC_STK = 2'h0;
    localparam logic [1:0] SRC_MPC = 2'h1;
    localparam logic [1:0] SRC_DRA = 2'h2;
    localparam logic [1:0] SRC_DRB = 2'h3;
    localparam logic [2:0] SEL_WIDE = 3'h5;
    // per select code: {cond high, cond low zero high, cond low zero low}
    localparam logic [7:0][5:0] SRC_TABLE = {6'h13, 6'h12, 6'h36, 6'h36,
                                             6'h1C, 6'h18, 6'h34, 6'h24};
    // register map
    localparam logic [7:0] OFS_ADDR = 8'h00;
    localparam logic [7:0] OFS_PTRS = 8'h04;
    localparam logic [7:0] OFS_LOOPS = 8'h08;
    localparam logic [7:0] OFS_SP_LOAD = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] RST_ADDR = 16'h0000;
endpackage : useq_pkg
`default_nettype wire

// file: src/useq_ctrl.sv
`default_nettype none
module useq_ctrl #(
    parameter int AW = 16,
    parameter int DEPTH = 65,
    parameter int BW = 8
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // microinstruction fields
    input wire logic [2:0] NEXT_ADDR_SELECT,
    input wire logic [2:0] STACK_OP_SELECT,
    input wire logic [2:0] COUNTER_OP_SELECT,
    input wire logic OUTPUT_SELECT,
    input wire logic ADVANCE_ENABLE,
    input wire logic PORT_A_OUT_EN_N,
    input wire logic PORT_B_OUT_EN_N,
    input wire logic [3:0] BRANCH_LOW_BITS,
    // status
    input wire logic COND_N,
    // data ports
    input wire logic [AW-1:0] DATA_PORT_A_IN,
    output logic [AW-1:0] DATA_PORT_A_OUT,
    output logic DATA_PORT_A_OE,
    input wire logic [AW-1:0] DATA_PORT_B_IN,
    output logic [AW-1:0] DATA_PORT_B_OUT,
    output logic DATA_PORT_B_OE,
    // microaddress and flag
    output logic [AW-1:0] MICRO_ADDR,
    output logic TERMINAL_COUNT_FLAG,
    // register bus
    input wire logic [BW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [BW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import useq_pkg::*;

    localparam int PW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] uprog_counter;
        logic [PW-1:0] stack_ptr;
        logic [PW-1:0] read_ptr;
        logic [DEPTH-1:0][AW-1:0] addr_stack;
        logic [AW-1:0] loop_reg_a;
        logic [AW-1:0] loop_reg_b;
        logic tc;
        logic [AW-1:0] pa_out;
        logic pa_oe;
        logic [AW-1:0] pb_out;
        logic pb_oe;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_type;

    state_type state_ff;
    state_type nxt_state;

    logic dec_a;
    logic dec_b;
    logic zero;
    logic both_low;
    logic low_zero_high;
    logic [5:0] row;
    logic [1:0] sel;
    logic rst_op;
    logic clr_now;
    logic pop_now;
    logic push_now;
    logic read_now;
    logic wr_take;
    logic rd_take;
    logic sp_load;
    logic [PW-1:0] wr_sp;
    logic [AW-1:0] top_word;
    logic [AW-1:0] rd_word;

    // zero is seen ahead of the edge so the same cycle can redirect
    assign dec_a = COUNTER_OP_SELECT == CNT_DEC_A || COUNTER_OP_SELECT == CNT_DEC_A_LD_B;
    assign dec_b = COUNTER_OP_SELECT == CNT_DEC_B || COUNTER_OP_SELECT == CNT_LD_A_DEC_B;
    assign zero = (dec_a && state_ff.loop_reg_a == AW'(1))
                || (dec_b && state_ff.loop_reg_b == AW'(1));
    assign both_low = !COND_N && !zero;
    assign low_zero_high = !COND_N && zero;

    assign row = SRC_TABLE[NEXT_ADDR_SELECT];
    assign sel = COND_N ? row[5:4] : (zero ? row[3:2] : row[1:0]);

    assign rst_op = STACK_OP_SELECT == STK_RESET;
    assign clr_now = rst_op || (STACK_OP_SELECT == STK_CLEAR && both_low);
    assign pop_now = (STACK_OP_SELECT == STK_POP_ELSE && !both_low)
                   || (STACK_OP_SELECT == STK_POP_IF && both_low);
    assign push_now = (STACK_OP_SELECT == STK_PUSH_ELSE && !both_low)
                    || (STACK_OP_SELECT == STK_PUSH_IF && both_low)
                    || (STACK_OP_SELECT == STK_PUSH_BUT && !low_zero_high);
    assign read_now = STACK_OP_SELECT == STK_READ && OUTPUT_SELECT;

    assign wr_take = state_ff.awready && S_AXI_AWVALID && S_AXI_WVALID;
    assign rd_take = state_ff.arready && S_AXI_ARVALID;
    assign sp_load = wr_take && S_AXI_AWADDR == OFS_SP_LOAD && S_AXI_WSTRB[0];
    // a loaded pointer beyond the stack would index past the array
    assign wr_sp = (S_AXI_WDATA[PW-1:0] > DEPTH_P) ? DEPTH_P : S_AXI_WDATA[PW-1:0];

    assign top_word = (state_ff.stack_ptr != '0)
                    ? state_ff.addr_stack[state_ff.stack_ptr - PW'(1)] : '0;
    assign rd_word = (state_ff.read_ptr != '0)
                   ? state_ff.addr_stack[state_ff.read_ptr - PW'(1)] : '0;

    always_comb begin
        nxt_state = state_ff;
        // next microaddress, chosen alongside the stack action
        case (sel)
            SRC_STK: nxt_state.uprog_counter = top_word;
            SRC_MPC: nxt_state.uprog_counter = state_ff.uprog_counter
                + (ADVANCE_ENABLE ? AW'(1) : AW'(0));
            SRC_DRA: nxt_state.uprog_counter = (NEXT_ADDR_SELECT == SEL_WIDE)
                ? {DATA_PORT_A_IN[AW-1:4], BRANCH_LOW_BITS} : DATA_PORT_A_IN;
            default: nxt_state.uprog_counter = (NEXT_ADDR_SELECT == SEL_WIDE)
                ? {DATA_PORT_B_IN[AW-1:4], BRANCH_LOW_BITS} : DATA_PORT_B_IN;
        endcase
        if (rst_op) begin
            nxt_state.uprog_counter = AW'(RST_ADDR);
        end
        // stack; bus load of the pointer overrides the microcoded action
        if (sp_load) begin
            nxt_state.stack_ptr = wr_sp;
            nxt_state.read_ptr = wr_sp;
        end else if (clr_now) begin
            nxt_state.stack_ptr = '0;
            nxt_state.read_ptr = '0;
        end else if (push_now && state_ff.stack_ptr < DEPTH_P) begin
            // return address is the one after the calling instruction
            nxt_state.addr_stack[state_ff.stack_ptr] = state_ff.uprog_counter + AW'(1);
            nxt_state.stack_ptr = state_ff.stack_ptr + PW'(1);
            nxt_state.read_ptr = state_ff.stack_ptr + PW'(1);
        end else if (pop_now && state_ff.stack_ptr != '0) begin
            nxt_state.stack_ptr = state_ff.stack_ptr - PW'(1);
            nxt_state.read_ptr = state_ff.stack_ptr - PW'(1);
        end else if (read_now && state_ff.read_ptr != '0) begin
            nxt_state.read_ptr = state_ff.read_ptr - PW'(1);
        end
        // loop registers, independent of condition and zero
        case (COUNTER_OP_SELECT)
            CNT_DEC_A: nxt_state.loop_reg_a = state_ff.loop_reg_a - AW'(1);
            CNT_LD_A: nxt_state.loop_reg_a = DATA_PORT_A_IN;
            CNT_DEC_A_LD_B: begin
                nxt_state.loop_reg_a = state_ff.loop_reg_a - AW'(1);
                nxt_state.loop_reg_b = DATA_PORT_B_IN;
            end
            CNT_LD_AB: begin
                nxt_state.loop_reg_a = DATA_PORT_A_IN;
                nxt_state.loop_reg_b = DATA_PORT_B_IN;
            end
            CNT_DEC_B: nxt_state.loop_reg_b = state_ff.loop_reg_b - AW'(1);
            CNT_LD_B: nxt_state.loop_reg_b = DATA_PORT_B_IN;
            CNT_LD_A_DEC_B: begin
                nxt_state.loop_reg_a = DATA_PORT_A_IN;
                nxt_state.loop_reg_b = state_ff.loop_reg_b - AW'(1);
            end
            default: nxt_state.loop_reg_a = state_ff.loop_reg_a;
        endcase
        nxt_state.tc = zero;
        // port drivers are registered, so the pins lag the registers by one cycle
        nxt_state.pa_oe = !PORT_A_OUT_EN_N;
        nxt_state.pa_out = OUTPUT_SELECT ? rd_word : state_ff.loop_reg_a;
        nxt_state.pb_oe = !PORT_B_OUT_EN_N;
        nxt_state.pb_out = state_ff.loop_reg_b;
        // write channel: address and data taken together
        nxt_state.awready = !state_ff.awready && !state_ff.bvalid
                          && S_AXI_AWVALID && S_AXI_WVALID;
        nxt_state.wready = nxt_state.awready;
        if (wr_take) begin
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = (S_AXI_AWADDR == OFS_ADDR || S_AXI_AWADDR == OFS_PTRS
                || S_AXI_AWADDR == OFS_LOOPS || S_AXI_AWADDR == OFS_SP_LOAD)
                ? RESP_OKAY : RESP_SLVERR;
        end else if (state_ff.bvalid && S_AXI_BREADY) begin
            nxt_state.bvalid = 1'b0;
        end
        // read channel
        nxt_state.arready = !state_ff.arready && !state_ff.rvalid && S_AXI_ARVALID;
        if (rd_take) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp = RESP_OKAY;
            case (S_AXI_ARADDR)
                OFS_ADDR: nxt_state.rdata = 32'(state_ff.uprog_counter);
                OFS_PTRS: nxt_state.rdata = (32'(state_ff.read_ptr) << 16)
                                          | 32'(state_ff.stack_ptr);
                OFS_LOOPS: nxt_state.rdata = (32'(state_ff.loop_reg_b) << 16)
                                           | 32'(state_ff.loop_reg_a);
                OFS_SP_LOAD: nxt_state.rdata = 32'(state_ff.stack_ptr);
                default: begin
                    nxt_state.rdata = 32'h0000_0000;
                    nxt_state.rresp = RESP_SLVERR;
                end
            endcase
        end else if (state_ff.rvalid && S_AXI_RREADY) begin
            nxt_state.rvalid = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign MICRO_ADDR = state_ff.uprog_counter;
    assign TERMINAL_COUNT_FLAG = state_ff.tc;
    assign DATA_PORT_A_OUT = state_ff.pa_out;
    assign DATA_PORT_A_OE = state_ff.pa_oe;
    assign DATA_PORT_B_OUT = state_ff.pb_out;
    assign DATA_PORT_B_OE = state_ff.pb_oe;
    assign S_AXI_AWREADY = state_ff.awready;
    assign S_AXI_WREADY = state_ff.wready;
    assign S_AXI_BVALID = state_ff.bvalid;
    assign S_AXI_BRESP = state_ff.bresp;
    assign S_AXI_ARREADY = state_ff.arready;
    assign S_AXI_RVALID = state_ff.rvalid;
    assign S_AXI_RDATA = state_ff.rdata;
    assign S_AXI_RRESP = state_ff.rresp;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_push_req;
        push_now && !sp_load && state_ff.stack_ptr < DEPTH_P;
    endsequence
    sequence s_pop_req;
        pop_now && !sp_load && state_ff.stack_ptr != '0;
    endsequence

    a_push_step: assert property (s_push_req |=>
        state_ff.stack_ptr == $past(state_ff.stack_ptr) + PW'(1)
        && top_word == $past(MICRO_ADDR) + AW'(1))
        else $error("push did not store and step the pointer");
    a_pop_step: assert property (s_pop_req |=>
        state_ff.stack_ptr == $past(state_ff.stack_ptr) - PW'(1))
        else $error("pop did not step the pointer down");
    a_reset_code: assert property (rst_op && !sp_load |=>
        MICRO_ADDR == '0 && state_ff.stack_ptr == '0 && state_ff.read_ptr == '0)
        else $error("reset code left state behind");
    a_clear_hold: assert property (STACK_OP_SELECT == STK_CLEAR && !both_low
        && !sp_load |=> $stable(state_ff.stack_ptr))
        else $error("clear code changed pointer when it should hold");
    a_read_walk: assert property (read_now && state_ff.read_ptr != '0 && !sp_load
        |=> state_ff.read_ptr == $past(state_ff.read_ptr) - PW'(1)
        && $stable(state_ff.stack_ptr))
        else $error("stack read disturbed the pointers");
    a_no_dual_dec: assert property (dec_a |=>
        state_ff.loop_reg_b == $past(state_ff.loop_reg_b)
        || state_ff.loop_reg_b == $past(DATA_PORT_B_IN))
        else $error("loop register B decremented alongside A");
    a_load_both: assert property (COUNTER_OP_SELECT == CNT_LD_AB |=>
        state_ff.loop_reg_a == $past(DATA_PORT_A_IN)
        && state_ff.loop_reg_b == $past(DATA_PORT_B_IN))
        else $error("load both failed");
    a_port_a_drive: assert property (!OUTPUT_SELECT && !PORT_A_OUT_EN_N |=>
        DATA_PORT_A_OE && DATA_PORT_A_OUT == $past(state_ff.loop_reg_a))
        else $error("port A not showing loop register A");
    a_continue_step: assert property (sel == SRC_MPC && ADVANCE_ENABLE && !rst_op |=>
        MICRO_ADDR == $past(MICRO_ADDR) + AW'(1))
        else $error("continue did not advance");
    a_repeat_hold: assert property (sel == SRC_MPC && !ADVANCE_ENABLE && !rst_op |=>
        $stable(MICRO_ADDR))
        else $error("repeat changed the address");
    a_tc_raise: assert property (dec_a && state_ff.loop_reg_a == AW'(1) |=>
        TERMINAL_COUNT_FLAG)
        else $error("terminal count missed");

    // pins and address lag the request by one edge, so these look one cycle on
    a_push_except: assert property (STACK_OP_SELECT == STK_PUSH_BUT
        && low_zero_high && !sp_load |=> $stable(state_ff.stack_ptr))
        else $error("push-except code pushed on a low-zero cycle");
    a_read_idle: assert property (STACK_OP_SELECT == STK_READ && !OUTPUT_SELECT
        && !sp_load |=> $stable(state_ff.stack_ptr) && $stable(state_ff.read_ptr))
        else $error("read code moved a pointer with output select low");
    a_clear_both: assert property (clr_now && !sp_load |=>
        state_ff.stack_ptr == '0 && state_ff.read_ptr == '0)
        else $error("clear left a pointer nonzero");
    a_port_b_drive: assert property (!PORT_B_OUT_EN_N |=>
        DATA_PORT_B_OE && DATA_PORT_B_OUT == $past(state_ff.loop_reg_b))
        else $error("port B not showing loop register B");
    a_stack_branch: assert property (sel == SRC_STK && !rst_op |=>
        MICRO_ADDR == $past(top_word))
        else $error("stack branch took the wrong address");
    a_port_branch: assert property (sel == SRC_DRA && NEXT_ADDR_SELECT != SEL_WIDE
        && !rst_op |=> MICRO_ADDR == $past(DATA_PORT_A_IN))
        else $error("port A branch took the wrong address");
endmodule : useq_ctrl
`default_nettype wire

// file: tb/far_side.sv
`default_nettype none
module far_side (
    // clock
    input wire logic clk,
    // port a pin
    input wire logic [15:0] a_out,
    input wire logic a_oe,
    input wire logic [15:0] a_ext,
    output logic [15:0] a_in,
    // port b pin
    input wire logic [15:0] b_out,
    input wire logic b_oe,
    input wire logic [15:0] b_ext,
    output logic [15:0] b_in,
    // outside drivers present
    input wire logic ext_en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] a_last_ff;
    logic [15:0] b_last_ff;
    // a released pin with no outside driver flips every cycle so stale data never reads as valid
    assign a_in = a_oe ? a_out : (ext_en ? a_ext : ~a_last_ff);
    assign b_in = b_oe ? b_out : (ext_en ? b_ext : ~b_last_ff);
    always_ff @(posedge clk) begin
        a_last_ff <= a_in;
        b_last_ff <= b_in;
    end
endmodule : far_side
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import useq_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, output_select = 1'b0, adv = 1'b0, cond_n = 1'b1;
    logic pa_n = 1'b1, pb_n = 1'b1, ext_en = 1'b1;
    logic [2:0] nas = 3'h2, sos = 3'h7, cos = 3'h0;
    logic [15:0] ext_a = 16'h0, ext_b = 16'h0, pc = 16'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic a_oe, b_oe, tcf, awready, wready, bvalid, arready, rvalid;
    logic [15:0] a_in, a_out, b_in, b_out, maddr;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int bad_count = 0, compares = 0;
    // source per select code: 0 stack, 1 counter, 2 A, 3 B, 4 A low bits, 5 B low bits
    localparam int HI_SRC [8] = '{2, 3, 1, 1, 3, 5, 1, 1};
    localparam int LO_SRC [8] = '{0, 0, 0, 0, 2, 4, 2, 3};
    localparam string OPA = "HDLDLHHL";
    localparam string OPB = "HHHLLDLD";
    localparam string OPS = "RRRCHHHPPPHHHUUUHHUHUDDDHHH";

    useq_ctrl useq_ctrl_i (
        .SYS_CLK(sys_clk), .RESETN(resetn), .NEXT_ADDR_SELECT(nas), .STACK_OP_SELECT(sos),
        .COUNTER_OP_SELECT(cos), .OUTPUT_SELECT(output_select), .ADVANCE_ENABLE(adv),
        .PORT_A_OUT_EN_N(pa_n), .PORT_B_OUT_EN_N(pb_n), .BRANCH_LOW_BITS(4'h9),
        .COND_N(cond_n), .DATA_PORT_A_IN(a_in), .DATA_PORT_A_OUT(a_out), .DATA_PORT_A_OE(a_oe),
        .DATA_PORT_B_IN(b_in), .DATA_PORT_B_OUT(b_out), .DATA_PORT_B_OE(b_oe),
        .MICRO_ADDR(maddr), .TERMINAL_COUNT_FLAG(tcf),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );
    far_side far_side_i (
        .clk(sys_clk), .a_out(a_out), .a_oe(a_oe), .a_ext(ext_a), .a_in(a_in),
        .b_out(b_out), .b_oe(b_oe), .b_ext(ext_b), .b_in(b_in), .ext_en(ext_en)
    );

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic results();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic guard(input int n);
        if (n >= 50) begin
            bad_count++;
            results();
        end
    endtask : guard

    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        guard(n);
        check("write resp", 32'(bresp), 32'(er));
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] ad, input logic [31:0] want, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        guard(n);
        check("read data", rdata, want);
        check("read resp", 32'(rresp), 32'(er));
    endtask : axi_rd

    // one instruction, then a hold-everything word so it executes exactly once
    task automatic step(input logic [2:0] na, so, co, input logic cn, av, os);
        @(posedge sys_clk);
        nas <= na;
        sos <= so;
        cos <= co;
        cond_n <= cn;
        adv <= av;
        output_select <= os;
        @(posedge sys_clk);
        nas <= 3'h2;
        sos <= STK_READ;
        cos <= 3'h0;
        cond_n <= 1'b1;
        adv <= 1'b0;
        output_select <= 1'b0;
        #1;
    endtask : step

    task automatic setx(input logic [15:0] a, b);
        @(posedge sys_clk);
        ext_a <= a;
        ext_b <= b;
    endtask : setx

    function automatic logic [15:0] pick(input int s, input logic [15:0] p);
        case (s)
            0: return 16'h1235;
            1: return p + 16'h1;
            2: return 16'h1234;
            3: return 16'h0ABC;
            4: return 16'h1239;
            default: return 16'h0AB9;
        endcase
    endfunction : pick

    function automatic logic [15:0] after(input byte op, input logic [15:0] old, ld);
        case (op)
            "D": return old - 16'h1;
            "L": return ld;
            default: return old;
        endcase
    endfunction : after

    task automatic t_continue();
        for (int k = 0; k < 4; k++) begin
            step({k[1], 1'b1, k[0]}, STK_READ, 3'h0, 1'b1, 1'b1, 1'b0);
            pc = pc + 16'h1;
            check("continue", 32'(maddr), 32'(pc));
        end
        step(3'h6, STK_READ, 3'h0, 1'b1, 1'b0, 1'b0);
        check("repeat", 32'(maddr), 32'(pc));
        $display("test continue done");
    endtask : t_continue

    task automatic t_branch();
        setx(16'h1234, 16'h0ABC);
        step(3'h0, STK_READ, 3'h0, 1'b1, 1'b1, 1'b0);
        step(3'h2, STK_PUSH_ELSE, 3'h0, 1'b1, 1'b1, 1'b0);
        pc = 16'h1235;
        check("call", 32'(maddr), 32'(pc));
        axi_rd(OFS_PTRS, 32'h0001_0001, RESP_OKAY);
        for (int k = 0; k < 16; k++) begin
            step(k[3:1], STK_READ, 3'h0, k[0], 1'b1, 1'b0);
            pc = pick(k[0] ? HI_SRC[k[3:1]] : LO_SRC[k[3:1]], pc);
            check("branch", 32'(maddr), 32'(pc));
        end
        step(3'h0, STK_POP_IF, 3'h0, 1'b0, 1'b1, 1'b0);
        check("return", 32'(maddr), 32'h1235);
        axi_rd(OFS_PTRS, 32'h0, RESP_OKAY);
        $display("test branch done");
    endtask : t_branch

    task automatic t_loop();
        setx(16'h0002, 16'h0ABC);
        step(3'h2, STK_READ, CNT_LD_A, 1'b1, 1'b0, 1'b0);
        setx(16'h0200, 16'h0ABC);
        step(3'h4, STK_READ, CNT_DEC_A, 1'b0, 1'b1, 1'b0);
        check("loop back", 32'(maddr), 32'h0200);
        check("count flag", 32'(tcf), 32'h0);
        step(3'h4, STK_READ, CNT_DEC_A, 1'b0, 1'b1, 1'b0);
        check("loop exit", 32'(maddr), 32'h0201);
        check("count flag", 32'(tcf), 32'h1);
        pc = 16'h0201;
        axi_wr(OFS_ADDR, 32'h0000_FFFF, RESP_OKAY);
        axi_rd(OFS_ADDR, 32'(pc), RESP_OKAY);
        axi_wr(8'h10, 32'h0, RESP_SLVERR);
        axi_rd(8'h10, 32'h0, RESP_SLVERR);
        $display("test loop and bus done");
    endtask : t_loop

    task automatic t_count();
        for (int k = 0; k < 8; k++) begin
            setx(16'h0010, 16'h0020);
            step(3'h2, STK_READ, CNT_LD_AB, 1'b1, 1'b0, 1'b0);
            setx(16'h0055, 16'h0066);
            step(3'h2, STK_READ, k[2:0], k[0], 1'b0, 1'b0);
            axi_rd(OFS_LOOPS, {after(OPB[k], 16'h0020, 16'h0066),
                   after(OPA[k], 16'h0010, 16'h0055)}, RESP_OKAY);
        end
        setx(16'h0A5A, 16'h0B5B);
        step(3'h2, STK_READ, CNT_LD_AB, 1'b1, 1'b0, 1'b0);
        @(posedge sys_clk);
        pa_n <= 1'b0;
        pb_n <= 1'b0;
        ext_en <= 1'b0;
        repeat (2) step(3'h2, STK_READ, 3'h0, 1'b1, 1'b0, 1'b0);
        check("port a", {a_oe, 15'h0, a_out}, 32'h8000_0A5A);
        check("port b", {b_oe, 15'h0, b_out}, 32'h8000_0B5B);
        @(posedge sys_clk);
        pa_n <= 1'b1;
        pb_n <= 1'b1;
        ext_en <= 1'b1;
        repeat (2) step(3'h2, STK_READ, 3'h0, 1'b1, 1'b0, 1'b0);
        check("ports off", 32'({a_oe, b_oe}), 32'h0);
        $display("test counters and ports done");
    endtask : t_count

    task automatic t_stack();
        byte op;
        logic [31:0] want;
        setx(16'h0001, 16'h0001);
        for (int s = 0; s < 9; s++) begin
            for (int c = 0; c < 3; c++) begin
                axi_wr(OFS_SP_LOAD, 32'h3, RESP_OKAY);
                step(3'h2, STK_READ, CNT_LD_A, 1'b1, 1'b0, 1'b0);
                step(3'h2, (s == 8) ? STK_READ : s[2:0], (c == 1) ? CNT_DEC_A : 3'h0,
                     c == 2, 1'b0, s != 8);
                op = OPS[s * 3 + c];
                want = (op == "H") ? 32'h0003_0003 : (op == "P") ? 32'h0002_0002 :
                       (op == "U") ? 32'h0004_0004 : (op == "D") ? 32'h0002_0003 : 32'h0;
                check("count flag", 32'(tcf), 32'(c == 1));
                axi_rd(OFS_PTRS, want, RESP_OKAY);
            end
        end
        $display("test stack done");
    endtask : t_stack

    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        t_continue();
        t_branch();
        t_loop();
        t_count();
        t_stack();
        results();
    end
endmodule : testbench
`default_nettype wire
